// ===== rtl/ild_level_detector.v
/*
  Input level detector with demultiplex delay, gated or interpolated
  update, rectifier, leaky/peak/plain integrator, interval counter and
  a test input word, plus a small result FIFO.
  Assumes one 25 MHz clock, a synchronous active-high reset, and that
  the sample source and the microprocessor write port are synchronous.
*/
`timescale 1ns/1ns
`include "ild_map.vh"

module ild_fifo #(
  parameter WIDTH = 40,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] in_data,
  input wire in_valid,
  output wire in_ready,
  output reg [WIDTH-1:0] out_data,
  output wire out_valid,
  input wire out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  assign in_ready = (count != DEPTH[AW:0]);
  assign out_valid = (count != {(AW+1){1'b0}});
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @* begin
    out_data = mem[rd_ptr];
  end

  always @(posedge clk) begin
    if (reset) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        mem[wr_ptr] <= in_data;
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (pop) begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (push && !pop) begin
        count <= count + 1'b1;
      end else if (pop && !push) begin
        count <= count - 1'b1;
      end
    end
  end
endmodule // ild_fifo

// Functional notes
// - Bits 6:4 of input control set clocks waited after strobe; zero means none.
// - All-ones delay code takes the sample seven clocks after the strobe.
// - Gated mode updates the detector only on clocks with the strobe, once.
// - Interpolated mode updates every clock, input zeroed while strobe is high.
// - Bit 21 ones-complements negative samples before detection; else unchanged.
// - Bit 20 free-runs ignoring interval; clear stops accumulating at expiry.
// - Bits 19:18 choose leak gain one, 2^-8, 2^-12 or 2^-16.
// - Bits 17:16 select leaky integrator, peak detector or plain integrator.
// - Interval field holds samples minus two, giving 2 to 65537 samples.
// - Any start write clears the accumulator and restarts the interval count.
// - Interval completion sets status word bit 1.
// - Test input word may replace samples to mixers or to the detector.
// - Test strobe is channel bit 11 or test-strobe writes, chosen by bit 12.
// - Each test-strobe write gives one strobe when that source is selected.
module ild_level_detector (
  input wire clk,
  input wire reset,
  input wire wr_en,
  input wire wr_indirect,
  input wire [15:0] wr_addr,
  input wire [31:0] wr_data,
  input wire [15:0] sample_in,
  input wire sample_strobe_in,
  output reg [15:0] mixer_sample,
  output reg mixer_strobe,
  output reg [39:0] level_out,
  output reg [15:0] status_word,
  output reg [31:0] config_readback,
  output wire [39:0] result_data,
  output wire result_valid,
  input wire result_ready
);
  localparam ST_IDLE = 1'b0;
  localparam ST_RUN = 1'b1;

  reg [15:0] input_format_control;
  reg [31:0] level_detector_config;
  reg [15:0] test_input_word;
  reg [15:0] chan_ctrl;
  reg test_write_pulse;
  reg [`ILD_DEMUX_DEPTH-1:0] strobe_pipe;
  reg [15:0] taken_sample;
  reg [39:0] acc;
  // One bit wider than the field so the 65537-sample interval does not wrap
  reg [16:0] interval_count;
  reg state;
  reg next_state;
  reg done_flag;
  wire global_wr;
  wire start_wr;
  wire test_strobe;
  wire det_strobe;
  wire [15:0] det_data;
  wire [2:0] demux_delay;
  wire interp_mode;
  wire delayed_strobe;
  wire update;
  wire [15:0] formatted;
  wire signed [15:0] rectified;
  wire signed [39:0] x_scaled;
  wire signed [39:0] x_ext;
  wire signed [39:0] leak_step;
  wire [1:0] det_mode;
  wire free_run;
  wire last_sample;
  wire fifo_in_ready;
  wire finish;
  reg signed [39:0] next_acc;

  function [4:0] leak_shift;
    input [1:0] code;
    begin
      case (code)
        2'b00: leak_shift = `ILD_LEAK_SHIFT_1;
        2'b01: leak_shift = `ILD_LEAK_SHIFT_2;
        2'b10: leak_shift = `ILD_LEAK_SHIFT_3;
        default: leak_shift = `ILD_LEAK_SHIFT_4;
      endcase
    end
  endfunction

  function hit;
    input ind;
    input [15:0] addr;
    input [15:0] target;
    input target_ind;
    begin
      hit = (ind == target_ind) && (addr == target);
    end
  endfunction

  assign global_wr = wr_en && !wr_indirect;
  assign start_wr = global_wr && hit(1'b0, wr_addr, `ILD_START_ADDR, 1'b0);

  // Register writes; write-only strobe locations store nothing
  always @(posedge clk) begin
    if (reset) begin
      input_format_control <= `ILD_FMT_RESET;
      level_detector_config <= `ILD_CFG_RESET;
      test_input_word <= `ILD_TEST_WORD_RESET;
      chan_ctrl <= `ILD_CHAN_CTRL_RESET;
      test_write_pulse <= 1'b0;
    end else begin
      // One pulse per write to the test strobe location
      test_write_pulse <= global_wr && hit(1'b0, wr_addr, `ILD_TEST_STROBE_ADDR, 1'b0);
      if (wr_en && hit(wr_indirect, wr_addr, `ILD_FMT_ADDR, 1'b0)) begin
        input_format_control <= wr_data[15:0];
      end
      if (wr_en && hit(wr_indirect, wr_addr, `ILD_CFG_ADDR, 1'b0)) begin
        // Bits 31:22 must be zero, so they are never stored
        level_detector_config <= wr_data & `ILD_CFG_WRITE_MASK;
      end
      if (wr_en && hit(wr_indirect, wr_addr, `ILD_TEST_WORD_ADDR, 1'b0)) begin
        test_input_word <= wr_data[15:0];
      end
      if (wr_en && hit(wr_indirect, wr_addr, `ILD_CHAN_CTRL_ADDR, 1'b1)) begin
        chan_ctrl <= wr_data[15:0];
      end
    end
  end

  // Test strobe source: level bit or write pulse
  assign test_strobe = chan_ctrl[`ILD_CHAN_STROBE_SEL_BIT] ? test_write_pulse :
                       chan_ctrl[`ILD_CHAN_TEST_STROBE_BIT];

  // Test word replaces the external stream where routed
  assign det_strobe = chan_ctrl[`ILD_CHAN_TEST_TO_DET_BIT] ? test_strobe : sample_strobe_in;
  assign det_data = chan_ctrl[`ILD_CHAN_TEST_TO_DET_BIT] ? test_input_word : sample_in;

  always @(posedge clk) begin
    if (reset) begin
      mixer_sample <= 16'h0000;
      mixer_strobe <= 1'b0;
    end else if (chan_ctrl[`ILD_CHAN_TEST_TO_MIX_BIT]) begin
      mixer_sample <= test_input_word;
      mixer_strobe <= test_strobe;
    end else begin
      mixer_sample <= sample_in;
      mixer_strobe <= sample_strobe_in;
    end
  end

  // Demultiplex delay: the strobe is walked down a short pipe
  assign demux_delay = input_format_control[`ILD_FMT_DEMUX_HI:`ILD_FMT_DEMUX_LO];
  assign interp_mode = input_format_control[`ILD_FMT_INTERP_BIT];

  always @(posedge clk) begin
    if (reset) begin
      strobe_pipe <= {`ILD_DEMUX_DEPTH{1'b0}};
    end else begin
      strobe_pipe <= {strobe_pipe[`ILD_DEMUX_DEPTH-2:0], det_strobe};
    end
  end

  // Code 000 uses the live strobe, code 111 the strobe seven clocks old
  assign delayed_strobe = (demux_delay == 3'b000) ? det_strobe : strobe_pipe[demux_delay - 3'd1];

  // Sample taken on the delayed strobe and held between strobes
  always @(posedge clk) begin
    if (reset) begin
      taken_sample <= 16'h0000;
    end else if (delayed_strobe) begin
      taken_sample <= det_data;
    end
  end

  // Gated: one update per strobed clock; interpolated: every clock
  assign update = (state == ST_RUN) && (interp_mode || delayed_strobe);
  // Interpolated input is zero while the strobe is high
  assign formatted = interp_mode ? (delayed_strobe ? 16'h0000 : det_data) :
                     (delayed_strobe ? det_data : taken_sample);

  // Ones complement of negative samples when rectifying
  assign rectified = (level_detector_config[`ILD_CFG_RECTIFY_BIT] && formatted[15]) ?
                     ~formatted : formatted;

  assign det_mode = level_detector_config[`ILD_CFG_MODE_HI:`ILD_CFG_MODE_LO];
  assign free_run = level_detector_config[`ILD_CFG_FREE_RUN_BIT];
  assign x_ext = {{24{rectified[15]}}, rectified};
  // Leaky path keeps 16 fraction bits so small gains do not vanish
  assign x_scaled = {{8{rectified[15]}}, rectified, 16'h0000};
  // A = 2^-k as an arithmetic right shift of the error term
  // Cast keeps the shift arithmetic; acc is stored unsigned
  assign leak_step = (x_scaled - $signed(acc)) >>> (5'd16 - leak_shift(
                     level_detector_config[`ILD_CFG_LEAK_HI:`ILD_CFG_LEAK_LO])) ;

  always @* begin
    next_acc = acc;
    case (det_mode)
      `ILD_MODE_LEAKY: next_acc = acc + leak_step;
      `ILD_MODE_PEAK: begin
        if (x_ext > $signed(acc)) begin
          next_acc = x_ext;
        end
      end
      `ILD_MODE_INTEG: next_acc = acc + x_ext;
      default: next_acc = acc;
    endcase
  end

  // Counter holds samples minus one; zero on an update is the last sample
  assign last_sample = (interval_count == 17'h0_0000);
  // A full result FIFO stalls completion; that sample is dropped meanwhile
  assign finish = update && last_sample && !free_run && fifo_in_ready;

  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: next_state = ST_IDLE;
      ST_RUN: begin
        if (finish) begin
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    if (start_wr) begin
      next_state = ST_RUN;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      state <= ST_IDLE;
      acc <= 40'h00_0000_0000;
      interval_count <= 17'h0_0000;
      done_flag <= 1'b0;
    end else begin
      state <= next_state;
      if (start_wr) begin
        // Written data is ignored; only the access matters
        acc <= 40'h00_0000_0000;
        interval_count <= {1'b0,
                           level_detector_config[`ILD_CFG_INTERVAL_HI:`ILD_CFG_INTERVAL_LO]} +
                          17'h0_0001;
      end else if (update && (free_run || !last_sample || fifo_in_ready)) begin
        acc <= next_acc;
        if (!free_run && !last_sample) begin
          interval_count <= interval_count - 17'h0_0001;
        end
      end
      // Completion sets the flag and beats a restart in the same clock
      if (finish) begin
        done_flag <= 1'b1;
      end else if (start_wr) begin
        done_flag <= 1'b0;
      end
    end
  end

  // Readable state; with free-run clear this value freezes once the interval completes
  always @(posedge clk) begin
    if (reset) begin
      level_out <= 40'h00_0000_0000;
      status_word <= 16'h0000;
      config_readback <= `ILD_CFG_RESET;
    end else begin
      level_out <= acc;
      status_word <= {14'h0000, done_flag, 1'b0};
      config_readback <= level_detector_config;
    end
  end

  ild_fifo #(
    .WIDTH(40),
    .DEPTH(4),
    .AW(2)
  ) u_result_fifo (
    .clk(clk),
    .reset(reset),
    .in_data(next_acc),
    .in_valid(finish),
    .in_ready(fifo_in_ready),
    .out_data(result_data),
    .out_valid(result_valid),
    .out_ready(result_ready)
  );
endmodule // ild_level_detector

// ===== rtl/ild_map.vh
/*
  Register locations, field positions, reset values and timing counts
  for the input level detector. Definitions only; include by bare name.
*/
`ifndef ILD_MAP_VH
`define ILD_MAP_VH

// Global write locations
`define ILD_FMT_ADDR 16'hf804
`define ILD_CFG_ADDR 16'hf805
`define ILD_START_ADDR 16'hf806
`define ILD_TEST_WORD_ADDR 16'hf807
`define ILD_TEST_STROBE_ADDR 16'hf808
// Indirect write location of the channel control register
`define ILD_CHAN_CTRL_ADDR 16'h0000

// Input format control fields
`define ILD_FMT_DEMUX_HI 6
`define ILD_FMT_DEMUX_LO 4
`define ILD_FMT_INTERP_BIT 3
`define ILD_DEMUX_DEPTH 7

// Configuration fields
`define ILD_CFG_RECTIFY_BIT 21
`define ILD_CFG_FREE_RUN_BIT 20
`define ILD_CFG_LEAK_HI 19
`define ILD_CFG_LEAK_LO 18
`define ILD_CFG_MODE_HI 17
`define ILD_CFG_MODE_LO 16
`define ILD_CFG_INTERVAL_HI 15
`define ILD_CFG_INTERVAL_LO 0
`define ILD_CFG_WRITE_MASK 32'h003f_ffff

// Channel control fields
`define ILD_CHAN_TEST_TO_DET_BIT 0
`define ILD_CHAN_TEST_TO_MIX_BIT 1
`define ILD_CHAN_TEST_STROBE_BIT 11
`define ILD_CHAN_STROBE_SEL_BIT 12

// Detector modes and leak shifts
`define ILD_MODE_LEAKY 2'b00
`define ILD_MODE_PEAK 2'b01
`define ILD_MODE_INTEG 2'b10
`define ILD_LEAK_SHIFT_1 5'd16
`define ILD_LEAK_SHIFT_2 5'd8
`define ILD_LEAK_SHIFT_3 5'd4
`define ILD_LEAK_SHIFT_4 5'd0

// Status word
`define ILD_STATUS_DONE_BIT 1

// Reset values
`define ILD_CFG_RESET 32'h0000_0000
`define ILD_FMT_RESET 16'h0000
`define ILD_TEST_WORD_RESET 16'h0000
`define ILD_CHAN_CTRL_RESET 16'h0000

`endif

// ===== verification/ild_chk.sv
/* Port checker for the level detector.
   Assumes a bind onto ild_level_detector and one clock. */
`timescale 1ns/1ns
module ild_chk (
  input wire clk,
  input wire reset,
  input wire wr_en,
  input wire wr_indirect,
  input wire [15:0] wr_addr,
  input wire [31:0] wr_data,
  input wire [15:0] mixer_sample,
  input wire mixer_strobe,
  input wire [15:0] status_word,
  input wire [31:0] config_readback,
  input wire [39:0] result_data,
  input wire result_valid,
  input wire result_ready
);
  reg mix_on;
  reg tst_sel;
  reg [15:0] tw_h;
  wire gw = wr_en && !wr_indirect;
  // Shadow of the channel routing so test strobes can be judged
  always @(posedge clk) begin
    if (reset) begin
      mix_on <= 1'b0;
      tst_sel <= 1'b0;
    end else if (wr_en && wr_indirect && wr_addr == 16'h0000) begin
      mix_on <= wr_data[1];
      tst_sel <= wr_data[12];
    end
    if (gw && wr_addr == 16'hf807)
      tw_h <= wr_data[15:0];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  a_cfg_readback: assert property (gw && wr_addr == 16'hf805 |-> ##2
    config_readback == ($past(wr_data, 2) & 32'h003f_ffff)) else $error("config readback wrong");
  a_cfg_reserved: assert property (config_readback[31:22] == 10'h000)
    else $error("config top bits set");
  a_start_clears: assert property (gw && wr_addr == 16'hf806 |-> ##2 !status_word[1])
    else $error("done not cleared by start");
  a_done_flag: assert property ($rose(result_valid) |=> status_word[1])
    else $error("done flag missing");
  a_fifo_hold: assert property (result_valid && !result_ready |=> result_valid)
    else $error("result dropped");
  a_fifo_data: assert property (result_valid && !result_ready |=> $stable(result_data))
    else $error("result changed while held");
  a_test_strobe: assert property (gw && wr_addr == 16'hf808 && tst_sel && mix_on
    |-> ##[1:3] mixer_strobe) else $error("test strobe missing");
  a_test_word: assert property (gw && wr_addr == 16'hf807 && mix_on
    |-> ##[1:3] mixer_sample == tw_h) else $error("test word not routed");
endmodule // ild_chk
bind ild_level_detector ild_chk ild_chk_inst (.clk(clk), .reset(reset), .wr_en(wr_en),
  .wr_indirect(wr_indirect), .wr_addr(wr_addr), .wr_data(wr_data),
  .mixer_sample(mixer_sample), .mixer_strobe(mixer_strobe), .status_word(status_word),
  .config_readback(config_readback), .result_data(result_data),
  .result_valid(result_valid), .result_ready(result_ready));

// ===== verification/ild_src.sv
/* Sample source model: new word every clock, one-clock strobe.
   Assumes go and per come from the bench. */
`timescale 1ns/1ns
module ild_src (
  input wire clk,
  input wire go,
  input wire [3:0] per,
  output reg [15:0] smp = 16'h0000,
  output reg stb = 1'b0
);
  reg [3:0] cnt = 4'h0;
  // Data moves every clock so a late take never sees a stale word
  always @(posedge clk) begin
    smp <= $urandom;
    cnt <= (cnt >= per) ? 4'h0 : cnt + 4'h1;
    stb <= go && cnt == 4'h0;
  end
endmodule // ild_src

// ===== verification/tb.sv
/* Self-checking bench with a reference model of the detector.
   Assumes the source model and the bound checker. */
`timescale 1ns/1ns
module tb;
  reg clk = 1'b0;
  reg reset = 1'b1;
  reg wr_en = 1'b0;
  reg wr_indirect = 1'b0;
  reg [15:0] wr_addr = 16'h0000;
  reg [31:0] wr_data = 32'h0000_0000;
  reg result_ready = 1'b1;
  reg go = 1'b1;
  reg [3:0] per = 4'h3;
  wire [15:0] sample_in;
  wire sample_strobe_in;
  wire [39:0] result_data;
  wire result_valid;
  wire [15:0] status_word;
  wire [39:0] level_out;
  longint last_res = 0;
  logic [1:0] tsrc = 2'b00;
  wire gw = wr_en && !wr_indirect;
  int errors = 0;
  int num_checks = 0;
  int nexp = 0;
  int nres = 0;
  int md, kk, rect, fr, dly, interp, tsel, itv, upd, run;
  longint acc, x;
  logic [7:0] dsh = 8'h00;
  logic tpend = 1'b0;
  logic [15:0] tw = 16'h0000;
  longint exp_q[$];
  always #20 clk = ~clk;
  ild_src ild_src_inst (.clk(clk), .go(go), .per(per), .smp(sample_in),
    .stb(sample_strobe_in));
  ild_level_detector ild_level_detector_inst (.clk(clk), .reset(reset), .wr_en(wr_en),
    .wr_indirect(wr_indirect), .wr_addr(wr_addr), .wr_data(wr_data), .sample_in(sample_in),
    .sample_strobe_in(sample_strobe_in), .mixer_sample(), .mixer_strobe(), .level_out(level_out),
    .status_word(status_word), .config_readback(), .result_data(result_data),
    .result_valid(result_valid), .result_ready(result_ready));
  task automatic cmp_res(input string n, input longint e, input logic [39:0] g);
    num_checks++;
    if (g !== e[39:0]) begin
      errors++;
      $display("unexpected %s: expected %h seen %h", n, e[39:0], g);
    end
  endtask
  task automatic cmp_bit(input string n, input logic e, input logic g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s: expected %b seen %b", n, e, g);
    end
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task wr(input logic ind, input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_indirect <= ind;
    wr_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task wt(input int n);
    int i;
    for (i = 0; i < 3000 && nres < n; i++) @(posedge clk);
    cmp_bit("result count", 1'b1, nres >= n);
  endtask
  task run1(input logic [15:0] f, input logic [31:0] c);
    int i;
    int n;
    n = nexp + 1;
    wr(1'b0, 16'hf804, {16'h0000, f});
    wr(1'b0, 16'hf805, c);
    wr(1'b0, 16'hf806, $urandom);
    for (i = 0; i < 3000 && nexp < n; i++) @(posedge clk);
    if (result_ready) begin
      wt(n);
      @(negedge clk);
      cmp_res("level_out", last_res, level_out);
    end
  endtask
  // Reference model: reads the same write port and samples as the design
  always @(posedge clk) begin
    if (result_valid === 1'b1 && result_ready === 1'b1) begin
      nres++;
      cmp_res("result_data", exp_q.size() ? exp_q.pop_front() : -1, result_data);
    end
    dsh = {dsh[6:0], tsel ? (tsrc[1] ? tpend : tsrc[0]) : sample_strobe_in};
    tpend = gw && wr_addr == 16'hf808;
    if (run && (interp || dsh[dly])) begin
      x = tsel ? $signed(tw) : $signed(sample_in);
      if (interp && dsh[dly]) x = 0;
      if (rect && x < 0) x = ~x;
      if (md == 0) acc += ((x <<< 16) - acc) >>> kk;
      else if (md == 1) acc = (x > acc) ? x : acc;
      else if (md == 2) acc += x;
      upd += !fr;
      if (upd == itv + 2) begin
        exp_q.push_back(acc);
        last_res = acc;
        nexp++;
        run = 0;
      end
    end
    if (gw && wr_addr == 16'hf806) begin
      acc = 0;
      upd = 0;
      run = 1;
    end
    if (gw && wr_addr == 16'hf805) begin
      rect = wr_data[21];
      fr = wr_data[20];
      kk = wr_data[19:18] ? 4 + 4 * wr_data[19:18] : 0;
      md = wr_data[17:16];
      itv = wr_data[15:0];
    end
    if (gw && wr_addr == 16'hf804) begin
      dly = wr_data[6:4];
      interp = wr_data[3];
    end
    if (gw && wr_addr == 16'hf807) tw = wr_data[15:0];
    if (wr_en && wr_indirect && wr_addr == 16'h0000) begin
      tsel = wr_data[0];
      tsrc = wr_data[12:11];
    end
  end
  initial begin
    repeat (40000) @(posedge clk);
    errors++;
    $display("unexpected watchdog: expected finish seen timeout");
    print_verdict;
  end
  initial begin
    int i;
    void'($urandom(74083));
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    // Every delay and mode, leak codes 0, 1 and 3 in leaky mode, with interval 0 as the short boundary
    for (i = 0; i < 12; i++) begin
      per <= 4'h1 + 4'($urandom_range(7));
      run1({9'h000, i[2:0], i[3], 3'h0},
        {10'h000, i[0], 1'b0, i[2:1], 2'(i % 3), 16'(i ? $urandom_range(5) : 0)});
      $display("test %0d done", i);
    end
    wr(1'b0, 16'hf805, 32'h0014_0005);
    wr(1'b0, 16'hf806, 32'h0000_0000);
    repeat (60) @(posedge clk);
    cmp_bit("result_valid", 1'b0, result_valid);
    wr(1'b0, 16'hf805, 32'h0004_0005);
    wt(nres + 1);
    @(negedge clk);
    cmp_res("level_out", last_res, level_out);
    $display("test free run done");
    result_ready <= 1'b0;
    for (i = 0; i < 4; i++) run1(16'h0000, 32'h0002_0000 | $urandom_range(3));
    repeat (3) @(posedge clk);
    cmp_bit("result_valid", 1'b1, result_valid);
    result_ready <= 1'b1;
    wt(nexp);
    $display("test fifo done");
    go <= 1'b0;
    wr(1'b1, 16'h0000, 32'h0000_1003);
    // Only test strobe writes feed this run, so completion is awaited after the three strobe writes
    wr(1'b0, 16'hf804, 32'h0000_0000);
    wr(1'b0, 16'hf805, 32'h0002_0001);
    wr(1'b0, 16'hf806, 32'h0000_0000);
    for (i = 0; i < 3; i++) begin
      wr(1'b0, 16'hf807, $urandom);
      wr(1'b0, 16'hf808, 32'h0000_0000);
    end
    wt(nres + 1);
    // Level strobe source: channel bit 11 strobes on every clock
    wr(1'b1, 16'h0000, 32'h0000_0803);
    run1(16'h0000, 32'h0001_0002);
    wr(1'b0, 16'hf807, 32'h0000_0000);
    wr(1'b1, 16'h0000, 32'h0000_0000);
    $display("test word done");
    print_verdict;
  end
endmodule // tb
